// ---- logic/eisfe_pkg.sv ----
// package: constants and types of the eeprom two-wire slave front end
//
// Behaviour
// RULE_01 - write-protect high blocks every write to the whole array
// RULE_02 - write-protect low, or floating, lets writes through
// RULE_03 - write-protect high: select and address acked, data bytes not
// RULE_04 - bus ignored until power-on reset releases, then standby
// RULE_05 - power-on reset indication again: stop answering the bus
// RULE_06 - start is data falling while clock stays high
// RULE_07 - master opens every instruction with a start
// RULE_08 - outside a write cycle, start is watched and resynchronises anytime
// RULE_09 - stop is data rising while clock high; it ends the exchange
// RULE_10 - stop after an unacknowledged read byte leaves device in standby
// RULE_11 - stop closing a write instruction starts the write cycle
// RULE_12 - received bits are taken on the clock rising edge
// RULE_13 - master changes data only while clock low, except start/stop
// RULE_14 - transmitter releases data after eight bits; receiver acks ninth
// RULE_15 - master sends select byte most significant bit first
// RULE_16 - last select bit: 1 means read, 0 means write
// RULE_17 - matching select byte is acked in the ninth bit time
// RULE_18 - mismatching select byte: drive nothing, standby until next start
// RULE_19 - device is slave only, timed by the master's clock
// RULE_20 - array is 2K bytes, eleven address bits
// RULE_21 - write cycle completes within its maximum time after stop
// RULE_22 - select byte: type in b7..b4, high address b3..b1, direction b0
// RULE_23 - only a stop right after a data byte ack starts a write
// RULE_24 - during a write cycle, data output off and no answer
package eisfe_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int TW_MS = 5;
   localparam int TW_CYC = TW_MS * (CLK_HZ / 1000);
   localparam int AW = 11;
   localparam int MEM_DEPTH = 2048;
   localparam int PAGE_LEN = 16;
   localparam logic [7:0] MEM_RST = 8'hff;
   // arbitrary device type value
   localparam logic [3:0] DEV_TYPE_RST = 4'h5;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_PEEK_ADDR = 8'h08;
   localparam logic [7:0] OFS_PEEK_DATA = 8'h0c;
   localparam logic [7:0] OFS_WR_COUNT = 8'h10;
   localparam int CTRL_EN_BIT = 4;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_RW_BIT = 1;
   localparam int ST_WP_BIT = 2;
   localparam int ST_LOW_BIT = 3;
   localparam int ST_STATE_LSB = 8;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_END = 4'h9;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_DEVSEL = 3'b001,
      S_ADDR = 3'b010,
      S_DATA = 3'b011,
      S_TX = 3'b100
   } eisfe_state_t;
endpackage : eisfe_pkg

// ---- logic/eisfe_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module eisfe_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= d_in;
         q_ff <= meta_ff;
      end
   end

   assign q_out = q_ff;
endmodule : eisfe_sync

// ---- logic/eisfe_top.sv ----
// two-wire eeprom slave front end with ahb-lite register port
`timescale 1ns/1ps
module eisfe_top
   import eisfe_pkg::*;
#(
   parameter int TW_CYCLES = TW_CYC,
   // arbitrary device type value
   parameter logic [3:0] DEV_TYPE_INIT = DEV_TYPE_RST
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic write_protect_in,
   input wire logic supply_low_in
);
   ////////////////////////////////////////////////////////////////////
   // pin sampling and line events
   logic [3:0] sync_q;
   logic scl_s;
   logic sda_s;
   logic wp_s;
   logic low_s;
   logic scl_d_ff;
   logic sda_d_ff;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;

   eisfe_sync #(.W(4)) u_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .d_in({scl_in, sda_in, write_protect_in, supply_low_in}),
      .q_out(sync_q)
   );

   assign scl_s = sync_q[3];
   assign sda_s = sync_q[2];
   // only a solid high protects; low or floating pin writes
   assign wp_s = (sync_q[1] == 1'b1); // RULE_02
   assign low_s = sync_q[0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // same level as the synchroniser reset: no false edge after reset
         scl_d_ff <= 1'b0;
         sda_d_ff <= 1'b0;
      end else begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   assign scl_rise = scl_s && !scl_d_ff;
   assign scl_fall = !scl_s && scl_d_ff;
   assign start_ev = scl_s && scl_d_ff && sda_d_ff && !sda_s; // RULE_06
   assign stop_ev = scl_s && scl_d_ff && !sda_d_ff && sda_s; // RULE_09

   ////////////////////////////////////////////////////////////////////
   // register state
   logic [31:0] ctrl_ff;
   logic [31:0] nxt_ctrl;
   logic [AW-1:0] peek_ff;
   logic [AW-1:0] nxt_peek;
   logic [31:0] wcount_ff;
   logic [31:0] nxt_wcount;
   logic dp_wr_ff;
   logic nxt_dp_wr;
   logic [7:0] dp_ofs_ff;
   logic [7:0] nxt_dp_ofs;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic ap_take;
   logic [3:0] dev_type;
   logic slave_en;

   ////////////////////////////////////////////////////////////////////
   // serial engine state
   eisfe_state_t state_ff;
   eisfe_state_t nxt_state;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic [7:0] shift_ff;
   logic [7:0] nxt_shift;
   logic oe_ff;
   logic nxt_oe;
   logic rw_ff;
   logic nxt_rw;
   logic mack_ff;
   logic nxt_mack;
   logic slot10_ff;
   logic nxt_slot10;
   logic [AW-1:0] addr_ff;
   logic [AW-1:0] nxt_addr;
   logic [AW-5:0] page_ff;
   logic [AW-5:0] nxt_page;
   logic [7:0] pbuf_ff [PAGE_LEN];
   logic [7:0] nxt_pbuf [PAGE_LEN];
   logic [PAGE_LEN-1:0] pval_ff;
   logic [PAGE_LEN-1:0] nxt_pval;
   logic [7:0] mem_ff [MEM_DEPTH];
   logic [7:0] mem_rd;
   logic sel_match;
   logic wr_go;
   logic busy;
   logic wr_done;

   assign dev_type = ctrl_ff[3:0];
   assign slave_en = ctrl_ff[CTRL_EN_BIT];
   assign mem_rd = mem_ff[addr_ff];
   assign sel_match = (shift_ff[7:4] == dev_type) && slave_en; // RULE_22

   eisfe_wtimer #(.TW_CYCLES(TW_CYCLES)) u_wtimer (
      .clk(hclk),
      .rst_n(hresetn),
      .start(wr_go),
      .busy(busy),
      .done(wr_done)
   );

   ////////////////////////////////////////////////////////////////////
   // serial engine next state
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_shift = shift_ff;
      nxt_oe = oe_ff;
      nxt_rw = rw_ff;
      nxt_mack = mack_ff;
      nxt_slot10 = slot10_ff;
      nxt_addr = addr_ff;
      nxt_page = page_ff;
      nxt_pbuf = pbuf_ff;
      nxt_pval = pval_ff;
      wr_go = 1'b0;
      if (wr_done) begin
         nxt_pval = '0;
      end
      if (low_s || busy) begin
         // supply low or write cycle: bus fully ignored
         nxt_state = S_IDLE; // RULE_05 RULE_24
         nxt_oe = 1'b0;
         nxt_cnt = '0;
         nxt_slot10 = 1'b0;
      end else if (start_ev) begin
         nxt_state = S_DEVSEL; // RULE_08 RULE_07
         nxt_cnt = '0;
         nxt_oe = 1'b0;
         nxt_slot10 = 1'b0;
         nxt_pval = '0;
      end else if (stop_ev) begin
         if (slot10_ff && state_ff == S_DATA && pval_ff != '0) begin
            wr_go = 1'b1; // RULE_11 RULE_23
         end else begin
            nxt_pval = '0;
         end
         nxt_state = S_IDLE; // RULE_10
         nxt_oe = 1'b0;
         nxt_cnt = '0;
         nxt_slot10 = 1'b0;
      end else if (state_ff != S_IDLE) begin
         if (scl_rise) begin
            if (cnt_ff < BIT_ACK) begin
               nxt_cnt = cnt_ff + 4'h1;
               if (state_ff != S_TX) begin
                  nxt_shift = {shift_ff[6:0], sda_s}; // RULE_12 RULE_13 RULE_15
               end
            end else if (cnt_ff == BIT_END && state_ff == S_TX) begin
               nxt_mack = !sda_s;
            end
         end else if (scl_fall) begin
            // tenth slot spans its whole clock high; its fall closes it
            nxt_slot10 = 1'b0; // RULE_23
            if (cnt_ff == BIT_ACK) begin
               nxt_cnt = BIT_END;
               unique case (state_ff)
                  S_DEVSEL: begin
                     if (sel_match) begin
                        nxt_oe = 1'b1; // RULE_17
                        nxt_rw = shift_ff[0]; // RULE_16
                        nxt_addr[AW-1:8] = shift_ff[3:1];
                     end else begin
                        nxt_state = S_IDLE; // RULE_18
                     end
                  end
                  S_ADDR: begin
                     nxt_oe = 1'b1; // RULE_03
                     nxt_addr[7:0] = shift_ff;
                  end
                  S_DATA: begin
                     if (!wp_s) begin
                        nxt_oe = 1'b1;
                        nxt_pbuf[addr_ff[3:0]] = shift_ff;
                        nxt_pval[addr_ff[3:0]] = 1'b1;
                        nxt_page = addr_ff[AW-1:4];
                        nxt_addr[3:0] = addr_ff[3:0] + 4'h1;
                     end // RULE_01 RULE_03
                  end
                  S_TX: begin
                     nxt_oe = 1'b0; // RULE_14
                  end
                  S_IDLE: begin
                     nxt_state = S_IDLE;
                  end
               endcase
            end else if (cnt_ff == BIT_END) begin
               nxt_oe = 1'b0; // RULE_14
               nxt_cnt = '0;
               unique case (state_ff)
                  S_DEVSEL: begin
                     if (rw_ff) begin
                        nxt_state = S_TX;
                        nxt_shift = mem_rd;
                        nxt_oe = !mem_rd[7];
                        nxt_addr = addr_ff + 11'h001; // RULE_20
                     end else begin
                        nxt_state = S_ADDR;
                     end
                  end
                  S_ADDR: begin
                     nxt_state = S_DATA;
                  end
                  S_DATA: begin
                     nxt_slot10 = oe_ff;
                  end
                  S_TX: begin
                     if (mack_ff) begin
                        nxt_shift = mem_rd;
                        nxt_oe = !mem_rd[7];
                        nxt_addr = addr_ff + 11'h001;
                     end else begin
                        nxt_state = S_IDLE; // RULE_10
                     end
                  end
                  S_IDLE: begin
                     nxt_state = S_IDLE;
                  end
               endcase
            end else if (state_ff == S_TX && cnt_ff != 4'h0) begin
               nxt_shift = {shift_ff[6:0], 1'b0};
               nxt_oe = !shift_ff[6];
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= S_IDLE; // RULE_04
         cnt_ff <= '0;
         shift_ff <= '0;
         oe_ff <= 1'b0;
         rw_ff <= 1'b0;
         mack_ff <= 1'b0;
         slot10_ff <= 1'b0;
         addr_ff <= '0;
         page_ff <= '0;
         pbuf_ff <= '{default: '0};
         pval_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         shift_ff <= nxt_shift;
         oe_ff <= nxt_oe;
         rw_ff <= nxt_rw;
         mack_ff <= nxt_mack;
         slot10_ff <= nxt_slot10;
         addr_ff <= nxt_addr;
         page_ff <= nxt_page;
         pbuf_ff <= nxt_pbuf;
         pval_ff <= nxt_pval;
      end
   end

   // array commit at the end of the write cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_ff <= '{default: MEM_RST};
      end else if (wr_done) begin
         for (int i = 0; i < PAGE_LEN; i++) begin
            if (pval_ff[i]) begin
               mem_ff[{page_ff, 4'(i)}] <= pbuf_ff[i];
            end
         end
      end
   end

   // open drain: only ever pulls low
   assign sda_out = 1'b0; // RULE_19
   assign sda_oe = oe_ff;

   ////////////////////////////////////////////////////////////////////
   // ahb-lite slave
   assign ap_take = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_ff;

   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_peek = peek_ff;
      nxt_wcount = wcount_ff;
      nxt_dp_wr = 1'b0;
      nxt_dp_ofs = dp_ofs_ff;
      nxt_rdata = rdata_ff;
      if (wr_done) begin
         nxt_wcount = wcount_ff + 32'h0000_0001;
      end
      if (dp_wr_ff) begin
         if (dp_ofs_ff == OFS_CTRL) begin
            nxt_ctrl = {27'h000_0000, hwdata[4:0]};
         end else if (dp_ofs_ff == OFS_PEEK_ADDR) begin
            nxt_peek = hwdata[AW-1:0];
         end
      end
      if (ap_take) begin
         nxt_dp_wr = hwrite;
         nxt_dp_ofs = haddr[7:0];
         nxt_rdata = '0;
         if (!hwrite && haddr[31:8] == 24'h00_0000) begin
            unique case (haddr[7:0])
               OFS_CTRL: nxt_rdata = nxt_ctrl;
               OFS_STATUS: begin
                  nxt_rdata[ST_BUSY_BIT] = busy;
                  nxt_rdata[ST_RW_BIT] = rw_ff;
                  nxt_rdata[ST_WP_BIT] = wp_s;
                  nxt_rdata[ST_LOW_BIT] = low_s;
                  nxt_rdata[ST_STATE_LSB+:3] = state_ff;
               end
               OFS_PEEK_ADDR: nxt_rdata[AW-1:0] = nxt_peek;
               OFS_PEEK_DATA: nxt_rdata[7:0] = mem_ff[nxt_peek];
               OFS_WR_COUNT: nxt_rdata = nxt_wcount;
               default: nxt_rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= {27'h000_0000, 1'b1, DEV_TYPE_INIT};
         peek_ff <= '0;
         wcount_ff <= '0;
         dp_wr_ff <= 1'b0;
         dp_ofs_ff <= '0;
         rdata_ff <= '0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         peek_ff <= nxt_peek;
         wcount_ff <= nxt_wcount;
         dp_wr_ff <= nxt_dp_wr;
         dp_ofs_ff <= nxt_dp_ofs;
         rdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   busy_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_24
      busy |=> !sda_oe && state_ff == S_IDLE)
      else $error("answered while write cycle runs");

   low_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
      low_s |=> !sda_oe && state_ff == S_IDLE)
      else $error("answered while supply low");

   start_seen_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
      start_ev && !busy && !low_s |=> state_ff == S_DEVSEL && cnt_ff == 4'h0)
      else $error("start not taken");

   stop_ends_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
      stop_ev && !busy && !low_s |=> state_ff == S_IDLE && !sda_oe)
      else $error("stop did not end exchange");

   write_trigger_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
      stop_ev && !busy && !low_s && slot10_ff && state_ff == S_DATA && pval_ff != '0
      |=> busy)
      else $error("write cycle not started");

   slot_only_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_23
      stop_ev && !busy && !low_s && !slot10_ff |=> !busy)
      else $error("write started outside tenth slot");

   protect_data_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
      scl_fall && cnt_ff == BIT_ACK && state_ff == S_DATA && wp_s && !busy && !low_s
      && !start_ev && !stop_ev |=> !sda_oe && pval_ff == $past(pval_ff))
      else $error("protected data byte accepted");

   select_ack_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_17
      scl_fall && cnt_ff == BIT_ACK && state_ff == S_DEVSEL && sel_match && !busy
      && !low_s && !start_ev && !stop_ev |=> sda_oe && cnt_ff == BIT_END)
      else $error("matching select not acked");

   select_miss_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18
      scl_fall && cnt_ff == BIT_ACK && state_ff == S_DEVSEL && !sel_match && !busy
      && !low_s && !start_ev && !stop_ev |=> !sda_oe [*2] ##0 state_ff == S_IDLE)
      else $error("mismatching select answered");

   rise_sample_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
      scl_rise && cnt_ff < BIT_ACK && state_ff inside {S_DEVSEL, S_ADDR, S_DATA}
      && !busy && !low_s && !start_ev && !stop_ev |=> shift_ff[0] == $past(sda_s))
      else $error("bit not taken at rising clock");
endmodule : eisfe_top

// ---- logic/eisfe_wtimer.sv ----
// nonvolatile write cycle timer
`timescale 1ns/1ps
module eisfe_wtimer #(
   parameter int TW_CYCLES = 200000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   output logic busy,
   output logic done
);
   localparam int CW = $clog2(TW_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(TW_CYCLES - 1);

   logic busy_ff;
   logic nxt_busy;
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;

   always_comb begin
      nxt_busy = busy_ff;
      nxt_cnt = cnt_ff;
      done = 1'b0;
      if (busy_ff) begin
         if (cnt_ff == LAST) begin
            nxt_busy = 1'b0; // RULE_21
            nxt_cnt = '0;
            done = 1'b1;
         end else begin
            nxt_cnt = cnt_ff + 1'b1;
         end
      end else if (start) begin
         nxt_busy = 1'b1;
         nxt_cnt = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff <= 1'b0;
         cnt_ff <= '0;
      end else begin
         busy_ff <= nxt_busy;
         cnt_ff <= nxt_cnt;
      end
   end

   assign busy = busy_ff;

   wtime_step_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_21
      busy_ff && cnt_ff != LAST |=> busy_ff && cnt_ff == $past(cnt_ff) + 1'b1)
      else $error("write timer skipped a count");
endmodule : eisfe_wtimer

// ---- tb/eisfe_i2c_master.sv ----
// two-wire bus master model that clocks and drives the serial link
`timescale 1ns/1ps
module eisfe_i2c_master (
   input wire logic hclk,
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   logic sda_drv = 1'b1;
   initial scl = 1'b1;
   // open drain with pull-up: line low if either side pulls
   assign sda = sda_drv & ~sda_oe;
   ////////////////////////////////////////////////////////////////////////
   task wt(input int n);
      repeat (n) @(posedge hclk);
   endtask : wt
   task start_c;
      sda_drv <= 1'b1;
      wt(2);
      scl <= 1'b1;
      wt(4);
      sda_drv <= 1'b0;
      wt(4);
      scl <= 1'b0;
   endtask : start_c
   task stop_c;
      sda_drv <= 1'b0;
      wt(2);
      scl <= 1'b1;
      wt(4);
      sda_drv <= 1'b1;
      wt(4);
   endtask : stop_c
   // data changes only while clock low
   task bit_c(input logic b, output logic s);
      sda_drv <= b;
      wt(2);
      scl <= 1'b1;
      wt(3);
      s = sda;
      wt(1);
      scl <= 1'b0;
      wt(2);
   endtask : bit_c
   task byte_wr(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_c(d[i], s);
      bit_c(1'b1, s);
      ack = ~s;
   endtask : byte_wr
   task byte_rd(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_c(1'b1, d[i]);
      bit_c(~more, s);
   endtask : byte_rd
endmodule : eisfe_i2c_master

// ---- tb/eisfe_top_tb_top.sv ----
// self-checking bench for the two-wire eeprom front end
`timescale 1ns/1ps
module eisfe_top_tb_top;
   import eisfe_pkg::*;
   localparam int TW = 400;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic scl;
   logic sda;
   logic sda_oe;
   logic wp = 1'b0;
   logic low = 1'b0;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic ack;
   logic [7:0] b;
   always #12.5 hclk = ~hclk;
   eisfe_top #(.TW_CYCLES(TW)) u_eisfe_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .write_protect_in(wp), .supply_low_in(low));
   eisfe_i2c_master u_eisfe_i2c_master (.hclk(hclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   ////////////////////////////////////////////////////////////////////////
   task results;
      if (fails == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      d = hrdata;
   endtask : ahb
   task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0000_0000, rd);
      chk(n, rd, e);
   endtask : rchk
   task busy_is(input logic e);
      ahb(1'b0, OFS_STATUS, 32'h0000_0000, rd);
      chk("busy", 32'(rd[ST_BUSY_BIT]), 32'(e));
   endtask : busy_is
   task sel(input logic [7:0] v, input logic e);
      u_eisfe_i2c_master.start_c();
      u_eisfe_i2c_master.byte_wr(v, ack);
      chk("select ack", 32'(ack), 32'(e));
   endtask : sel
   task wb(input logic [7:0] v, input logic e);
      u_eisfe_i2c_master.byte_wr(v, ack);
      chk("byte ack", 32'(ack), 32'(e));
   endtask : wb
   task wait_free;
      ahb(1'b0, OFS_STATUS, 32'h0000_0000, rd);
      for (int i = 0; i < 300 && rd[ST_BUSY_BIT] !== 1'b0; i++)
         ahb(1'b0, OFS_STATUS, 32'h0000_0000, rd);
      chk("busy end", 32'(rd[ST_BUSY_BIT]), 32'h0000_0000);
   endtask : wait_free
   function automatic logic [7:0] dsel(input logic rw);
      return {DEV_TYPE_RST, 3'h2, rw};
   endfunction : dsel
   ////////////////////////////////////////////////////////////////////////
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk("ctrl", OFS_CTRL, 32'h0000_0010 | 32'(DEV_TYPE_RST));
      rchk("unmapped", 8'h20, 32'h0000_0000);
      // byte write to location 0x234
      sel(dsel(1'b0), 1'b1);
      wb(8'h34, 1'b1);
      wb(8'ha5, 1'b1);
      u_eisfe_i2c_master.stop_c();
      busy_is(1'b1);
      sel(dsel(1'b0), 1'b0);
      u_eisfe_i2c_master.stop_c();
      wait_free();
      ahb(1'b1, OFS_PEEK_ADDR, 32'h0000_0234, rd);
      rchk("array", OFS_PEEK_DATA, 32'h0000_00a5);
      rchk("count", OFS_WR_COUNT, 32'h0000_0001);
      // stop one bit after the data ack, not in the tenth slot
      sel(dsel(1'b0), 1'b1);
      wb(8'h35, 1'b1);
      wb(8'h5a, 1'b1);
      u_eisfe_i2c_master.bit_c(1'b0, ack);
      u_eisfe_i2c_master.stop_c();
      repeat (8) @(posedge hclk);
      busy_is(1'b0);
      rchk("count", OFS_WR_COUNT, 32'h0000_0001);
      // write-protected byte write
      wp <= 1'b1;
      sel(dsel(1'b0), 1'b1);
      wb(8'h34, 1'b1);
      wb(8'h3c, 1'b0);
      u_eisfe_i2c_master.stop_c();
      wait_free();
      rchk("array", OFS_PEEK_DATA, 32'h0000_00a5);
      wp <= 1'b0;
      // wrong type, then a fresh start and a random read
      sel({DEV_TYPE_RST ^ 4'h1, 3'h2, 1'b0}, 1'b0);
      sel(dsel(1'b0), 1'b1);
      wb(8'h34, 1'b1);
      sel(dsel(1'b1), 1'b1);
      u_eisfe_i2c_master.byte_rd(1'b0, b);
      chk("read byte", 32'(b), 32'h0000_00a5);
      u_eisfe_i2c_master.stop_c();
      ahb(1'b0, OFS_STATUS, 32'h0000_0000, rd);
      chk("state", 32'(rd[ST_STATE_LSB +: 3]), 32'(S_IDLE));
      // supply falling
      low <= 1'b1;
      repeat (4) @(posedge hclk);
      sel(dsel(1'b0), 1'b0);
      u_eisfe_i2c_master.stop_c();
      low <= 1'b0;
      // power-on reset in mid-run
      hresetn <= 1'b0;
      sel(dsel(1'b0), 1'b0);
      u_eisfe_i2c_master.stop_c();
      hresetn <= 1'b1;
      @(posedge hclk);
      sel(dsel(1'b0), 1'b1);
      u_eisfe_i2c_master.stop_c();
      repeat (8) @(posedge hclk);
      busy_is(1'b0);
      results();
   end
endmodule : eisfe_top_tb_top
